// File: hdl/spsd_consts.vh
// Constants for the serial-in parallel-sink driver.
`ifndef SPSD_CONSTS_VH
`define SPSD_CONSTS_VH
`define SPSD_CHANNELS     12
`define SPSD_FIFO_DEPTH   4
`define SPSD_CLEAR_VALUE  12'h000
`define SPSD_SYNC_STAGES  2
`define SPSD_PIN_IDLE     6'h04
`endif

// File: hdl/spsd_fifo.v
// Small flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/100ps
module spsd_fifo #(
  parameter WIDTH = 12,
  parameter DEPTH = 4
) (
  input  wire             clk_i,
  input  wire             rst_n_i,
  input  wire             clr_i,
  input  wire [WIDTH-1:0] in_data_i,
  input  wire             in_valid_i,
  output wire             in_ready_o,
  output wire [WIDTH-1:0] out_data_o,
  output wire             out_valid_o,
  input  wire             out_ready_i
);
  localparam AW = (DEPTH <= 2) ? 1 : $clog2(DEPTH);

  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0]    wr_q;
  reg [AW-1:0]    rd_q;
  reg [AW:0]      cnt_q;
  wire            push;
  wire            pop;
  integer         i;

  function [AW-1:0] bump;
    input [AW-1:0] p;
    begin
      if (p == DEPTH - 1)
        bump = {AW{1'b0}};
      else
        bump = p + 1'b1;
    end
  endfunction

  assign in_ready_o  = (cnt_q != DEPTH);
  assign out_valid_o = (cnt_q != 0);
  assign out_data_o  = mem_q[rd_q];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
      for (i = 0; i < DEPTH; i = i + 1)
        mem_q[i] <= {WIDTH{1'b0}};
    end
    else if (clr_i)
    begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
      begin
        mem_q[wr_q] <= in_data_i;
        wr_q        <= bump(wr_q);
      end
      if (pop)
        rd_q <= bump(rd_q);
      if (push && !pop)
        cnt_q <= cnt_q + 1'b1;
      else if (pop && !push)
        cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule

// File: hdl/spsd_top.v
// Serial-in, parallel open-drain sink driver with cascade output.
`timescale 1ns/100ps
`include "spsd_consts.vh"
module spsd_top #(
  parameter CHANNELS   = `SPSD_CHANNELS,
  parameter FIFO_DEPTH = `SPSD_FIFO_DEPTH
) (
  input  wire                mclk_i,
  input  wire                rst_n_i,
  input  wire                shift_clock_i,
  input  wire                latch_clock_i,
  input  wire                register_clear_n_i,
  input  wire                output_enable_n_i,
  input  wire                serial_data_input_i,
  input  wire                over_temp_i,
  output reg                 cascade_data_output_o,
  output reg  [CHANNELS-1:0] sink_channel_o,
  output reg  [CHANNELS-1:0] sink_channel_oe_o,
  output reg                 latch_overrun_o
);

  // ----------------------------------------------------------------
  // Edge helpers
  // ----------------------------------------------------------------
  // Both helpers look at synchronised levels only, never at a raw pin.
  function edge_rise;
    input now_lvl;
    input old_lvl;
    begin
      edge_rise = now_lvl & ~old_lvl;
    end
  endfunction

  function edge_fall;
    input now_lvl;
    input old_lvl;
    begin
      edge_fall = ~now_lvl & old_lvl;
    end
  endfunction

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  reg  rst_meta_q;
  reg  rst_sync_q;
  wire rst_n;

  assign rst_n = rst_sync_q;

  always @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rst_meta_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
    end
  end

  always @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rst_sync_q <= 1'b0;
    end
    else
    begin
      rst_sync_q <= rst_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Pin order: shift clock, latch clock, clear, enable, data, thermal.
  // The idle value keeps clear high and both clocks low, so no false
  // edge or spurious clear appears in the first cycles after reset.
  wire [5:0] pin_raw;
  reg  [5:0] pin_meta_q;
  reg  [5:0] pin_sync_q;
  reg        sck_prev_q;
  reg        lck_prev_q;

  assign pin_raw = {over_temp_i, serial_data_input_i, output_enable_n_i,
                    register_clear_n_i, latch_clock_i, shift_clock_i};

  always @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_meta_q <= `SPSD_PIN_IDLE;
    end
    else
    begin
      pin_meta_q <= pin_raw;
    end
  end

  always @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_sync_q <= `SPSD_PIN_IDLE;
    end
    else
    begin
      pin_sync_q <= pin_meta_q;
    end
  end

  always @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sck_prev_q <= 1'b0;
      lck_prev_q <= 1'b0;
    end
    else
    begin
      sck_prev_q <= pin_sync_q[0];
      lck_prev_q <= pin_sync_q[1];
    end
  end

  wire clr_n_s;
  wire oe_n_s;
  wire sdi_s;
  wire hot_s;
  wire sck_rise;
  wire sck_fall;
  wire lck_rise;

  assign clr_n_s  = pin_sync_q[2];
  assign oe_n_s   = pin_sync_q[3];
  assign sdi_s    = pin_sync_q[4];
  assign hot_s    = pin_sync_q[5];
  assign sck_rise = edge_rise(pin_sync_q[0], sck_prev_q);
  assign sck_fall = edge_fall(pin_sync_q[0], sck_prev_q);
  assign lck_rise = edge_rise(pin_sync_q[1], lck_prev_q);

  // ----------------------------------------------------------------
  // Shift register
  // ----------------------------------------------------------------
  // The data pin runs through the same two flops as the clock, so the
  // bit seen at a detected rise is the bit that stood at the pin edge.
  reg [CHANNELS-1:0] shift_q;

  always @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shift_q <= `SPSD_CLEAR_VALUE;
    end
    else if (!clr_n_s)
    begin
      shift_q <= `SPSD_CLEAR_VALUE;
    end
    else if (sck_rise)
    begin
      shift_q <= {shift_q[CHANNELS-2:0], sdi_s};
    end
  end

  // ----------------------------------------------------------------
  // Cascade output
  // ----------------------------------------------------------------
  // Retiming to the falling edge gives the next stage half a shift
  // period of hold, at the cost of that half period of latency.
  always @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cascade_data_output_o <= 1'b0;
    end
    else if (!clr_n_s)
    begin
      cascade_data_output_o <= 1'b0;
    end
    else if (sck_fall)
    begin
      cascade_data_output_o <= shift_q[CHANNELS-1];
    end
  end

  // ----------------------------------------------------------------
  // Latch path through the FIFO
  // ----------------------------------------------------------------
  // Each latch edge pushes a snapshot and the storage register drains
  // one word per cycle. Latch edges are two cycles apart at the least,
  // so a full FIFO is only a fault flag: that word is lost.
  wire [CHANNELS-1:0] fifo_data;
  wire                fifo_valid;
  wire                fifo_in_ready;
  wire                fifo_clear;
  reg  [CHANNELS-1:0] store_q;

  assign fifo_clear = ~clr_n_s;

  spsd_fifo #(
    .WIDTH (CHANNELS),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (mclk_i),
    .rst_n_i     (rst_n),
    .clr_i       (fifo_clear),
    .in_data_i   (shift_q),
    .in_valid_i  (lck_rise),
    .in_ready_o  (fifo_in_ready),
    .out_data_o  (fifo_data),
    .out_valid_o (fifo_valid),
    .out_ready_i (clr_n_s)
  );

  always @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      store_q <= `SPSD_CLEAR_VALUE;
    end
    else if (!clr_n_s)
    begin
      store_q <= `SPSD_CLEAR_VALUE;
    end
    else if (fifo_valid)
    begin
      store_q <= fifo_data;
    end
  end

  always @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      latch_overrun_o <= 1'b0;
    end
    else if (!clr_n_s)
    begin
      latch_overrun_o <= 1'b0;
    end
    else if (lck_rise && !fifo_in_ready)
    begin
      latch_overrun_o <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Output buffers and open-drain sinks
  // ----------------------------------------------------------------
  // The thermal input is already a comparator with hysteresis, so the
  // block only follows it: off above the trip, back on once it drops.
  wire                gate_on;
  wire [CHANNELS-1:0] buf_bits;

  assign gate_on  = clr_n_s & ~oe_n_s & ~hot_s;
  assign buf_bits = gate_on ? store_q : {CHANNELS{1'b0}};

  always @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sink_channel_o <= {CHANNELS{1'b0}};
    end
    else
    begin
      sink_channel_o <= {CHANNELS{1'b0}};
    end
  end

  always @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sink_channel_oe_o <= {CHANNELS{1'b0}};
    end
    else
    begin
      sink_channel_oe_o <= buf_bits;
    end
  end
endmodule

// File: verification/spsd_ctrl_model.sv
// Controller model that shifts and latches words into the driver.
`timescale 1ns/100ps
module spsd_ctrl_model (
  input  wire mclk_i,
  output reg  shift_clock_o,
  output reg  serial_data_o,
  output reg  latch_clock_o
);
  initial shift_clock_o = 1'b0;
  initial serial_data_o = 1'b0;
  initial latch_clock_o = 1'b0;
  // Data moves while the clock is low, half a period before the rise.
  task send(input logic [11:0] w);
    for (int i = 11; i >= 0; i--)
    begin
      serial_data_o <= w[i];
      repeat (4) @(posedge mclk_i);
      shift_clock_o <= 1'b1;
      repeat (4) @(posedge mclk_i);
      shift_clock_o <= 1'b0;
    end
    // Idle data shows the inverse so a stale bit cannot pass.
    serial_data_o <= ~w[0];
  endtask
  task latch();
    latch_clock_o <= 1'b1;
    repeat (4) @(posedge mclk_i);
    latch_clock_o <= 1'b0;
    repeat (4) @(posedge mclk_i);
  endtask
endmodule

// File: verification/spsd_top_assertions.sv
// Port checks for the serial-in parallel-sink driver.
`timescale 1ns/100ps
module spsd_top_assertions #(
  parameter CHANNELS = 12
) (
  input wire                mclk_i,
  input wire                rst_n_i,
  input wire                shift_clock_i,
  input wire                latch_clock_i,
  input wire                register_clear_n_i,
  input wire                output_enable_n_i,
  input wire                serial_data_input_i,
  input wire                over_temp_i,
  input wire                cascade_data_output_o,
  input wire [CHANNELS-1:0] sink_channel_o,
  input wire [CHANNELS-1:0] sink_channel_oe_o,
  input wire                latch_overrun_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);
  // Eight quiet samples outlast the five-cycle latch path.
  sequence quiet_s;
    (!latch_clock_i && !output_enable_n_i && register_clear_n_i
      && !over_temp_i) [*8];
  endsequence
  sequence clear_s;
    (!register_clear_n_i) [*5];
  endsequence
  a_sink_value_low: assert property (sink_channel_o == '0)
    else $error("sink value not zero");
  a_disable_all_off: assert property
    (output_enable_n_i [*4] |-> sink_channel_oe_o == '0)
    else $error("channel on while disabled");
  a_hot_all_off: assert property
    (over_temp_i [*4] |-> sink_channel_oe_o == '0)
    else $error("channel on while hot");
  a_clear_outputs_off: assert property
    (clear_s |-> sink_channel_oe_o == '0 && !cascade_data_output_o)
    else $error("outputs not cleared");
  a_clear_overrun: assert property (clear_s |-> !latch_overrun_o)
    else $error("overrun survives clear");
  a_casc_on_fall: assert property
    ($changed(cascade_data_output_o) |->
      !$past(shift_clock_i, 2) || !$past(register_clear_n_i, 2))
    else $error("cascade moved without shift fall");
  a_casc_hold_high: assert property
    ((shift_clock_i && register_clear_n_i) [*4] |->
      $stable(cascade_data_output_o))
    else $error("cascade moved while shift high");
  a_oe_only_latch: assert property
    (quiet_s |-> $stable(sink_channel_oe_o))
    else $error("channels moved without latch");
endmodule
bind spsd_top spsd_top_assertions #(.CHANNELS(CHANNELS)) i_chk (
  .mclk_i(mclk_i), .rst_n_i(rst_n_i), .shift_clock_i(shift_clock_i),
  .latch_clock_i(latch_clock_i), .over_temp_i(over_temp_i),
  .register_clear_n_i(register_clear_n_i),
  .output_enable_n_i(output_enable_n_i),
  .serial_data_input_i(serial_data_input_i),
  .cascade_data_output_o(cascade_data_output_o),
  .sink_channel_o(sink_channel_o), .sink_channel_oe_o(sink_channel_oe_o),
  .latch_overrun_o(latch_overrun_o));

// File: verification/tb.sv
// Self-checking bench for the serial-in parallel-sink driver.
`timescale 1ns/100ps
module tb;
  reg         mclk_i = 1'b0;
  reg         rst_n_i = 1'b0;
  reg         clr_n = 1'b0;
  reg         oe_n = 1'b1;
  reg         hot = 1'b0;
  reg  [11:0] cur = 12'h000;
  wire        sclk, sdat, lclk, casc, ovr;
  wire [11:0] sink, sink_oe;
  int         n_fail = 0;
  int         checks = 0;
  initial forever #50 mclk_i = ~mclk_i;
  spsd_ctrl_model i_ctrl (.mclk_i(mclk_i), .shift_clock_o(sclk),
    .serial_data_o(sdat), .latch_clock_o(lclk));
  spsd_top i_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .shift_clock_i(sclk), .latch_clock_i(lclk),
    .register_clear_n_i(clr_n), .output_enable_n_i(oe_n),
    .serial_data_input_i(sdat), .over_temp_i(hot),
    .cascade_data_output_o(casc), .sink_channel_o(sink),
    .sink_channel_oe_o(sink_oe), .latch_overrun_o(ovr));
  task finish_test();
    if (n_fail == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [11:0] seen, input logic [11:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t got %h want %h", $time, seen, exp);
    end
  endtask
  // Waits past the five-cycle latch path and three-cycle pin paths.
  task settle();
    repeat (8) @(posedge mclk_i);
  endtask
  task t_load(input logic [11:0] w);
    oe_n <= 1'b0;
    i_ctrl.send(w);
    i_ctrl.latch();
    settle();
    chk(sink_oe, w);
    chk(sink, 12'h000);
    chk({11'h000, ovr}, 12'h000);
    cur = w;
  endtask
  task t_cascade(input logic [11:0] w);
    i_ctrl.send(w);
    settle();
    chk(sink_oe, cur);
    chk({11'h000, casc}, {11'h000, w[11]});
    i_ctrl.latch();
    settle();
    chk(sink_oe, w);
    cur = w;
  endtask
  task t_enable();
    repeat (2)
    begin
      oe_n <= 1'b1;
      settle();
      chk(sink_oe, 12'h000);
      oe_n <= 1'b0;
      settle();
      chk(sink_oe, cur);
    end
  endtask
  task t_thermal();
    hot <= 1'b1;
    settle();
    chk(sink_oe, 12'h000);
    hot <= 1'b0;
    settle();
    chk(sink_oe, cur);
  endtask
  task t_clear();
    clr_n <= 1'b0;
    settle();
    chk(sink_oe, 12'h000);
    clr_n <= 1'b1;
    settle();
    chk(sink_oe, 12'h000);
    i_ctrl.latch();
    settle();
    chk(sink_oe, 12'h000);
    chk({11'h000, casc}, 12'h000);
  endtask
  initial
  begin
    repeat (10) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    repeat (10) @(posedge mclk_i);
    clr_n <= 1'b1;
    settle();
    t_load(12'hA5C);
    t_cascade(12'h3C6);
    t_enable();
    t_thermal();
    t_clear();
    finish_test();
  end
  initial
  begin
    repeat (20000) @(posedge mclk_i);
    n_fail++;
    finish_test();
  end
endmodule
